/* File: sp0_pkg.sv */
// Constants, types and the register map of serial port zero.
// Assumes a single 100 MHz system clock and an 8-bit register port.
`default_nettype none

package sp0_pkg;

    // ========================================================
    // Register port
    localparam int         ADDR_W    = 2;
    localparam logic [1:0] BUF_ADDR  = 2'h0;
    localparam logic [1:0] CTRL_ADDR = 2'h1;
    localparam logic [1:0] CFG_ADDR  = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } sp0_bus_req_type;

    // ========================================================
    // Control register fields
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_MULTI   = 5;
    localparam int CTRL_REN     = 4;
    localparam int CTRL_TB8     = 3;
    localparam int CTRL_RB8     = 2;
    localparam int CTRL_TI      = 1;
    localparam int CTRL_RI      = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ========================================================
    // Configuration register fields
    localparam int CFG_M0_FAST   = 0;
    localparam int CFG_M2_FAST   = 1;
    localparam int CFG_FRAME_CHK = 2;
    localparam logic [2:0] CFG_RESET = 3'h0;

    // ========================================================
    // Timing, in system clocks and oversample ticks
    localparam logic [3:0] M0_SLOW_DIV   = 4'hc;
    localparam logic [3:0] M0_FAST_DIV   = 4'h2;
    localparam logic [6:0] M2_SLOW_DIV   = 7'h40;
    localparam logic [6:0] M2_FAST_DIV   = 7'h20;
    localparam logic [6:0] OVERSAMPLE    = 7'h10;
    localparam logic [6:0] M2_SLOW_TICK  = M2_SLOW_DIV / OVERSAMPLE;
    localparam logic [6:0] M2_FAST_TICK  = M2_FAST_DIV / OVERSAMPLE;
    localparam logic [3:0] OS_LAST       = 4'hf;
    localparam logic [3:0] OS_MID        = 4'h7;
    localparam logic [8:0] M0_RX_PATTERN = 9'h1fe;

    typedef enum logic [1:0] {
        MODE_SHIFT     = 2'h0,
        MODE_UART8     = 2'h1,
        MODE_UART9_FIX = 2'h2,
        MODE_UART9_VAR = 2'h3
    } sp0_mode_type;

endpackage : sp0_pkg

`default_nettype wire

/* File: sp0_serial_port.sv */
// Serial port zero: shift-register mode plus three UART modes.
// Assumes the timer supplies 16x oversample ticks for modes 1 and 3,
// and that all pin inputs are already synchronous to mclk_in.
//
// How it works
// - Transmit and receive engines run independently
// - Receiver shifts while buffered byte unread
// - Buffer address: write transmits, read receives
// - Four modes, zero synchronous, others UART
// - Mode zero: 8 bits LSB first, clock out
// - Mode zero clock: sysclk/12 or sysclk/2
// - Mode one: 10-bit frame, stop to ninth
// - Mode two: 11-bit frame, ninth bit stored
// - Mode two baud: sysclk/32 or sysclk/64
// - Mode three like two, timer baud
// - Only buffer writes start transmission
// - Mode zero receive: enable set, done clear
// - UART receive starts on falling start edge
// - Mode zero transmit: rising edges, eight then done
// - Load 111111110, then activate receive
// - Clock out, sample on falling edge
// - Rise after eighth falling edge sets receive done
// - Missing stop sets firmware-cleared framing flag
// - Transmit frame begins at next baud edge
`timescale 1ns/1ps
`default_nettype none

module sp0_serial_port (
    input  wire logic                     mclk_in,
    input  wire logic                     reset_in,
    input  wire sp0_pkg::sp0_bus_req_type bus_req_in,
    output var  logic [7:0]               rdata_out,
    input  wire logic                     tx_os_tick_in,
    input  wire logic                     rx_os_tick_in,
    input  wire logic                     rx_data_pin_in,
    output var  logic                     rx_data_pin_out,
    output var  logic                     rx_data_pin_oe_out,
    output var  logic                     tx_pin_out
);
    import sp0_pkg::*;

    function automatic logic [3:0] m0_period(input logic fast);
        m0_period = fast ? M0_FAST_DIV : M0_SLOW_DIV;
    endfunction : m0_period

    // ========================================================
    // State encodings
    typedef enum logic [3:0] {
        M0_IDLE = 4'b0001,
        M0_TX   = 4'b0010,
        M0_LOAD = 4'b0100,
        M0_RX   = 4'b1000
    } sp0_m0_state_type;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_WAIT  = 3'b010,
        TX_SHIFT = 3'b100
    } sp0_tx_state_type;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'b001,
        RX_START = 3'b010,
        RX_DATA  = 3'b100
    } sp0_rx_state_type;

    // ========================================================
    // Registers
    sp0_mode_type     mode_reg;
    logic             multi_reg;
    logic             ren_reg;
    logic             tb8_reg;
    logic             rb8_reg;
    logic             ti_reg;
    logic             ri_reg;
    logic             fe_reg;
    logic [2:0]       cfg_reg;
    logic [7:0]       rxbuf_reg;
    logic [6:0]       m2_cnt_reg;

    sp0_m0_state_type m0_state_reg;
    logic [3:0]       m0_div_reg;
    logic [3:0]       m0_bit_reg;
    logic [8:0]       m0_shift_reg;
    logic             m0_clk_reg;

    sp0_tx_state_type tx_state_reg;
    logic [10:0]      tx_frame_reg;
    logic [3:0]       tx_bit_reg;
    logic [3:0]       tx_os_reg;
    logic             tx_line_reg;

    sp0_rx_state_type rx_state_reg;
    logic             rx_prev_reg;
    logic [3:0]       rx_os_reg;
    logic [3:0]       rx_cnt_reg;
    logic [9:0]       rx_shift_reg;

    // ========================================================
    // Register port decode
    wire wr_buf  = bus_req_in.wr && (bus_req_in.addr == BUF_ADDR);
    wire wr_ctrl = bus_req_in.wr && (bus_req_in.addr == CTRL_ADDR);
    wire wr_cfg  = bus_req_in.wr && (bus_req_in.addr == CFG_ADDR);
    wire is_m0   = (mode_reg == MODE_SHIFT);
    wire is_m1   = (mode_reg == MODE_UART8);
    wire is_m2   = (mode_reg == MODE_UART9_FIX);
    wire fcs     = cfg_reg[CFG_FRAME_CHK];

    wire [7:0] ctrl_view = {fcs ? fe_reg : mode_reg[1], mode_reg[0], multi_reg,
                            ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg};
    wire [7:0] rd_mux    = (bus_req_in.addr == BUF_ADDR)  ? rxbuf_reg :
                           (bus_req_in.addr == CTRL_ADDR) ? ctrl_view :
                           (bus_req_in.addr == CFG_ADDR)  ? {5'h00, cfg_reg} : 8'h00;

    // ========================================================
    // Baud ticks; mode two uses a fixed divider of the system clock
    wire [6:0] m2_tick_div = cfg_reg[CFG_M2_FAST] ? M2_FAST_TICK : M2_SLOW_TICK;
    wire       m2_tick     = (m2_cnt_reg == m2_tick_div - 7'h01);
    wire       tx_tick     = is_m2 ? m2_tick : tx_os_tick_in;
    wire       rx_tick     = is_m2 ? m2_tick : rx_os_tick_in;

    // ========================================================
    // Mode zero events
    wire [3:0] m0_p       = m0_period(cfg_reg[CFG_M0_FAST]);
    wire [3:0] m0_half    = m0_p >> 1;
    wire       m0_active  = (m0_state_reg == M0_TX) || (m0_state_reg == M0_RX);
    wire       m0_rise    = m0_active && (m0_div_reg == m0_half - 4'h1);
    wire       m0_fall    = m0_active && (m0_div_reg == m0_p - 4'h1);
    wire       m0_tx_done = (m0_state_reg == M0_TX) && m0_rise && (m0_bit_reg == 4'h7);
    wire       m0_rx_done = (m0_state_reg == M0_RX) && m0_rise && (m0_bit_reg == 4'h8);
    wire       m0_rx_go   = is_m0 && ren_reg && !ri_reg && !wr_buf;
    wire       m0_clk_next = (m0_state_reg == M0_IDLE) ? !(is_m0 && wr_buf) :
                             m0_rise ? 1'b1 : (m0_fall ? 1'b0 : m0_clk_reg);

    // ========================================================
    // Async transmit events
    wire       tx_bit_tick = tx_tick && (tx_os_reg == OS_LAST);
    wire [3:0] tx_bits     = is_m1 ? 4'ha : 4'hb;
    wire       tx_ti_set   = (tx_state_reg == TX_SHIFT) && tx_bit_tick && (tx_bit_reg == tx_bits - 4'h1);
    wire [10:0] tx_frame   = {1'b1, is_m1 ? 1'b1 : tb8_reg, bus_req_in.wdata, 1'b0};

    // ========================================================
    // Async receive events
    wire       rx_fall_seen = ren_reg && !is_m0 && rx_prev_reg && !rx_data_pin_in;
    wire       rx_sample    = (rx_state_reg == RX_DATA) && rx_tick && (rx_os_reg == OS_LAST);
    wire [3:0] rx_samples   = is_m1 ? 4'h9 : 4'ha;
    wire       rx_done      = rx_sample && (rx_cnt_reg == rx_samples - 4'h1);
    wire [9:0] rx_shift_in  = {rx_data_pin_in, rx_shift_reg[9:1]};
    wire [7:0] rx_byte      = is_m1 ? rx_shift_in[8:1] : rx_shift_in[7:0];
    wire       rx_ninth     = is_m1 ? rx_shift_in[9] : rx_shift_in[8];

    // Overrun: the unread byte wins, the new one is dropped
    wire       ri_set  = (m0_rx_done || rx_done) && !ri_reg;
    wire [7:0] new_rx  = m0_rx_done ? m0_shift_reg[8:1] : rx_byte;

    // ========================================================
    // Control, flags and read data
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            mode_reg <= sp0_mode_type'(CTRL_RESET[7:6]);
            {multi_reg, ren_reg, tb8_reg, rb8_reg, ti_reg, ri_reg} <= CTRL_RESET[5:0];
            fe_reg     <= 1'b0;
            cfg_reg    <= CFG_RESET;
            rxbuf_reg  <= 8'h00;
            rdata_out  <= 8'h00;
            m2_cnt_reg <= 7'h00;
        end else begin
            rdata_out  <= bus_req_in.rd ? rd_mux : 8'h00;
            m2_cnt_reg <= m2_tick ? 7'h00 : m2_cnt_reg + 7'h01;
            if (wr_ctrl) begin
                mode_reg  <= sp0_mode_type'({fcs ? mode_reg[1] : bus_req_in.wdata[CTRL_MODE_HI],
                                             bus_req_in.wdata[CTRL_MODE_LO]});
                multi_reg <= bus_req_in.wdata[CTRL_MULTI];
                ren_reg   <= bus_req_in.wdata[CTRL_REN];
                tb8_reg   <= bus_req_in.wdata[CTRL_TB8];
            end
            if (wr_cfg) begin
                cfg_reg <= bus_req_in.wdata[2:0];
            end
            // Hardware set wins over a same-cycle software clear
            ti_reg <= (wr_ctrl ? bus_req_in.wdata[CTRL_TI] : ti_reg) | m0_tx_done | tx_ti_set;
            ri_reg <= (wr_ctrl ? bus_req_in.wdata[CTRL_RI] : ri_reg) | ri_set;
            fe_reg <= ((wr_ctrl && fcs && !bus_req_in.wdata[CTRL_MODE_HI]) ? 1'b0 : fe_reg)
                      | (rx_done && !rx_shift_in[9]);
            if (ri_set) begin
                rxbuf_reg <= new_rx;
                rb8_reg   <= m0_rx_done ? rb8_reg : rx_ninth;
            end else if (wr_ctrl) begin
                rb8_reg <= bus_req_in.wdata[CTRL_RB8];
            end
        end
    end

    // ========================================================
    // Mode zero shift engine
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            m0_state_reg       <= M0_IDLE;
            m0_div_reg         <= 4'h0;
            m0_bit_reg         <= 4'h0;
            m0_shift_reg       <= 9'h000;
            m0_clk_reg         <= 1'b1;
            rx_data_pin_out    <= 1'b1;
            rx_data_pin_oe_out <= 1'b0;
        end else begin
            m0_div_reg <= (m0_div_reg == m0_p - 4'h1) ? 4'h0 : m0_div_reg + 4'h1;
            m0_clk_reg <= m0_clk_next;
            case (m0_state_reg)
                M0_IDLE: begin
                    m0_div_reg <= 4'h0;
                    m0_bit_reg <= 4'h0;
                    if (is_m0 && wr_buf) begin
                        m0_state_reg       <= M0_TX;
                        m0_shift_reg       <= {1'b1, bus_req_in.wdata};
                        rx_data_pin_out    <= bus_req_in.wdata[0];
                        rx_data_pin_oe_out <= 1'b1;
                    end else if (m0_rx_go) begin
                        m0_state_reg <= M0_LOAD;
                        m0_shift_reg <= M0_RX_PATTERN;
                    end
                end
                M0_TX: begin
                    if (m0_rise) begin
                        m0_bit_reg <= m0_bit_reg + 4'h1;
                        if (m0_tx_done) begin
                            m0_state_reg       <= M0_IDLE;
                            rx_data_pin_oe_out <= 1'b0;
                        end
                    end else if (m0_fall) begin
                        m0_shift_reg    <= {1'b1, m0_shift_reg[8:1]};
                        rx_data_pin_out <= m0_shift_reg[1];
                    end
                end
                M0_LOAD: begin
                    m0_state_reg <= M0_RX;
                    m0_div_reg   <= 4'h0;
                end
                M0_RX: begin
                    if (m0_rx_done) begin
                        m0_state_reg <= M0_IDLE;
                    end else if (m0_fall) begin
                        m0_shift_reg <= {rx_data_pin_in, m0_shift_reg[8:1]};
                        m0_bit_reg   <= m0_bit_reg + 4'h1;
                    end
                end
                default: begin
                    m0_state_reg <= M0_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Async transmitter; the oversample count free-runs so a frame
    // lines up with the baud clock rather than with the write
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            tx_state_reg <= TX_IDLE;
            tx_frame_reg <= 11'h7ff;
            tx_bit_reg   <= 4'h0;
            tx_os_reg    <= 4'h0;
            tx_line_reg  <= 1'b1;
            tx_pin_out   <= 1'b1;
        end else begin
            tx_pin_out <= is_m0 ? m0_clk_next : tx_line_reg;
            if (tx_tick) begin
                tx_os_reg <= tx_os_reg + 4'h1;
            end
            if (!is_m0 && wr_buf) begin
                tx_state_reg <= TX_WAIT;
                tx_frame_reg <= tx_frame;
            end else begin
                case (tx_state_reg)
                    TX_IDLE: begin
                        tx_line_reg <= 1'b1;
                    end
                    TX_WAIT: begin
                        if (tx_bit_tick) begin
                            tx_state_reg <= TX_SHIFT;
                            tx_line_reg  <= tx_frame_reg[0];
                            tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                            tx_bit_reg   <= 4'h1;
                        end
                    end
                    TX_SHIFT: begin
                        if (tx_bit_tick) begin
                            if (tx_bit_reg == tx_bits) begin
                                tx_state_reg <= TX_IDLE;
                                tx_line_reg  <= 1'b1;
                            end else begin
                                tx_line_reg  <= tx_frame_reg[0];
                                tx_frame_reg <= {1'b1, tx_frame_reg[10:1]};
                                tx_bit_reg   <= tx_bit_reg + 4'h1;
                            end
                        end
                    end
                    default: begin
                        tx_state_reg <= TX_IDLE;
                    end
                endcase
            end
        end
    end

    // ========================================================
    // Async receiver; start bit is checked at mid-bit to reject glitches
    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            rx_state_reg <= RX_IDLE;
            rx_prev_reg  <= 1'b1;
            rx_os_reg    <= 4'h0;
            rx_cnt_reg   <= 4'h0;
            rx_shift_reg <= 10'h000;
        end else begin
            rx_prev_reg <= rx_data_pin_in;
            case (rx_state_reg)
                RX_IDLE: begin
                    rx_os_reg  <= 4'h0;
                    rx_cnt_reg <= 4'h0;
                    if (rx_fall_seen) begin
                        rx_state_reg <= RX_START;
                    end
                end
                RX_START: begin
                    if (rx_tick) begin
                        rx_os_reg <= rx_os_reg + 4'h1;
                        if (rx_os_reg == OS_MID) begin
                            rx_state_reg <= rx_data_pin_in ? RX_IDLE : RX_DATA;
                            rx_os_reg    <= 4'h0;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_tick) begin
                        rx_os_reg <= rx_os_reg + 4'h1;
                    end
                    if (rx_sample) begin
                        rx_shift_reg <= rx_shift_in;
                        rx_cnt_reg   <= rx_cnt_reg + 4'h1;
                        if (rx_done) begin
                            rx_state_reg <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

endmodule : sp0_serial_port

`default_nettype wire

/* File: sp0_port_checker_sva.sv */
// Port checker for serial port zero, bound to the design top.
// Assumes the mode and rates change only by register writes while idle.
`timescale 1ns/1ps
`default_nettype none

module sp0_port_checker (
    input wire logic                     mclk_in,
    input wire logic                     reset_in,
    input wire sp0_pkg::sp0_bus_req_type bus_req_in,
    input wire logic [7:0]               rdata_out,
    input wire logic                     tx_os_tick_in,
    input wire logic                     rx_os_tick_in,
    input wire logic                     rx_data_pin_in,
    input wire logic                     rx_data_pin_out,
    input wire logic                     rx_data_pin_oe_out,
    input wire logic                     tx_pin_out
);
    import sp0_pkg::*;

    // ==========
    // Shadow state
    logic [1:0] mode_q;
    logic [2:0] cfg_q;
    logic [9:0] low_run;
    wire        ctrl_wr = bus_req_in.wr && (bus_req_in.addr == CTRL_ADDR);
    wire        cfg_wr  = bus_req_in.wr && (bus_req_in.addr == CFG_ADDR);
    wire        buf_wr  = bus_req_in.wr && (bus_req_in.addr == BUF_ADDR);
    wire        m2      = mode_q == MODE_UART9_FIX;
    // Mode 2 bits are counted in clocks, timer modes in ticks
    wire [9:0]  run_inc = m2 ? 10'h001 : {9'h000, tx_os_tick_in};
    wire [6:0]  bit_len = !m2 ? OVERSAMPLE : (cfg_q[CFG_M2_FAST] ? M2_FAST_DIV : M2_SLOW_DIV);

    always_ff @(posedge mclk_in) begin
        if (reset_in) begin
            mode_q   <= 2'h0;
            cfg_q    <= CFG_RESET;
            low_run  <= 10'h000;
        end else begin
            low_run  <= tx_pin_out ? 10'h000 : low_run + run_inc;
            if (ctrl_wr) begin
                mode_q <= {cfg_q[CFG_FRAME_CHK] ? mode_q[1] : bus_req_in.wdata[7], bus_req_in.wdata[6]};
            end
            if (cfg_wr) begin
                cfg_q <= bus_req_in.wdata[2:0];
            end
        end
    end

    // ==========
    // Assertions
    default clocking @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    AST_RDATA_IDLE: assert property (!bus_req_in.rd |=> rdata_out == 8'h00)
        else $error("read data not zero when idle");
    AST_UNMAPPED_READ: assert property (bus_req_in.rd && bus_req_in.addr == 2'h3 |=> rdata_out == 8'h00)
        else $error("unmapped read returned data");
    AST_CFG_READ: assert property (bus_req_in.rd && bus_req_in.addr == CFG_ADDR |=> rdata_out == {5'h00, cfg_q})
        else $error("config readback wrong");
    AST_MODE_READ: assert property (bus_req_in.rd && bus_req_in.addr == CTRL_ADDR |=>
        rdata_out[CTRL_MODE_LO] == mode_q[0] && (cfg_q[CFG_FRAME_CHK] || rdata_out[CTRL_MODE_HI] == mode_q[1]))
        else $error("mode readback wrong");
    AST_OE_MODE0: assert property (rx_data_pin_oe_out |-> mode_q == MODE_SHIFT)
        else $error("data pin driven outside shift mode");
    AST_TX_BY_WRITE: assert property ($rose(rx_data_pin_oe_out) |-> $past(buf_wr))
        else $error("shift transmit without buffer write");
    AST_M0_FAST_CLK: assert property (mode_q == MODE_SHIFT && cfg_q[CFG_M0_FAST] && $fell(tx_pin_out) |=> $rose(tx_pin_out))
        else $error("fast shift clock low phase not one cycle");
    AST_M0_SLOW_CLK: assert property (mode_q == MODE_SHIFT && !cfg_q[CFG_M0_FAST] && $fell(tx_pin_out) |=>
        !tx_pin_out [*5] ##1 tx_pin_out)
        else $error("slow shift clock low phase not six cycles");
    AST_UART_BIT_LEN: assert property (mode_q != MODE_SHIFT && $rose(tx_pin_out) |-> low_run % bit_len == 0)
        else $error("low run not whole bits");

endmodule : sp0_port_checker

bind sp0_serial_port sp0_port_checker u_checker (
    .mclk_in(mclk_in), .reset_in(reset_in), .bus_req_in(bus_req_in), .rdata_out(rdata_out),
    .tx_os_tick_in(tx_os_tick_in), .rx_os_tick_in(rx_os_tick_in), .rx_data_pin_in(rx_data_pin_in),
    .rx_data_pin_out(rx_data_pin_out), .rx_data_pin_oe_out(rx_data_pin_oe_out), .tx_pin_out(tx_pin_out));

`default_nettype wire

/* File: sp0_remote_model.sv */
// Remote partner of serial port zero: external shift register and UART peer.
// Assumes the bench resolves the shared data pin from the design's enable.
`timescale 1ns/1ps
`default_nettype none

module sp0_remote_model (
    input  wire logic       mclk_in,
    input  wire logic       uart_on_in,
    input  wire logic [7:0] bit_len_in,
    input  wire logic       tx_line_in,
    input  wire logic       data_line_in,
    output var  logic       line_out
);
    logic [10:0] frame     = 11'h000;
    logic [7:0]  cap       = 8'h00;
    logic [7:0]  shreg     = 8'hff;
    logic        uart_line = 1'b1;
    logic        clk_q     = 1'b1;
    logic        data_q    = 1'b1;
    int          i;

    assign line_out = uart_on_in ? uart_line : shreg[0];

    // ==========
    // Shift-register side
    // Enable drops with the last rise, so use the older data sample
    always @(posedge mclk_in) begin
        clk_q  <= tx_line_in;
        data_q <= data_line_in;
        if (!uart_on_in && tx_line_in && !clk_q) begin
            cap <= {data_q, cap[7:1]};
        end
    end

    // Far register shifts on the pin edge; spent bits return inverted
    always @(posedge tx_line_in iff !uart_on_in) begin
        shreg <= {~shreg[0], shreg[7:1]};
    end

    task automatic load_byte(input logic [7:0] b);
        shreg = b;
    endtask : load_byte

    // ==========
    // UART side: mid-bit sampler and frame sender
    always begin
        @(negedge tx_line_in iff uart_on_in);
        repeat (bit_len_in / 2) @(posedge mclk_in);
        for (i = 0; i < 11; i++) begin
            frame[i] = tx_line_in;
            repeat (bit_len_in) @(posedge mclk_in);
        end
    end

    task automatic send_frame(input logic [10:0] bits, input int blen);
        int k;
        for (k = 0; k < 11; k++) begin
            @(posedge mclk_in);
            uart_line <= bits[k];
            repeat (blen - 1) @(posedge mclk_in);
        end
        uart_line <= 1'b1;
    endtask : send_frame

endmodule : sp0_remote_model

`default_nettype wire

/* File: serial_port_zero_modes_bench.sv */
// Self-checking bench for serial port zero in all four modes.
// Assumes the remote model on the pins and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

`define CHECK_EQ(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module serial_port_zero_modes_bench;
    import sp0_pkg::*;

    logic            mclk_in  = 1'b0;
    logic            reset_in = 1'b1;
    sp0_bus_req_type bus_req  = '0;
    logic [7:0]      rdata;
    logic            tx_tick  = 1'b0, rx_tick = 1'b0;
    logic            pin_in, pin_out, pin_oe, tx_pin, model_line;
    logic            uart_on  = 1'b0;
    logic [7:0]      bit_len  = 8'h40;
    logic [7:0]      tick_cnt = 8'h00;
    int              bad_count = 0;
    int              checks    = 0;
    int              cycles    = 0;
    int              seed      = 32'h39e9;
    // Transmit ticks every 4 clocks, receive every 2: unequal rates
    logic [1:0]      modes [4] = '{2'h2, 2'h2, 2'h1, 2'h3};
    logic [7:0]      cfgs  [4] = '{8'h00, 8'h02, 8'h00, 8'h00};
    int              txlen [4] = '{64, 32, 64, 64};
    int              rxlen [4] = '{64, 32, 32, 32};

    assign pin_in = pin_oe ? pin_out : model_line;

    sp0_serial_port u_dut (
        .mclk_in(mclk_in), .reset_in(reset_in), .bus_req_in(bus_req), .rdata_out(rdata),
        .tx_os_tick_in(tx_tick), .rx_os_tick_in(rx_tick), .rx_data_pin_in(pin_in),
        .rx_data_pin_out(pin_out), .rx_data_pin_oe_out(pin_oe), .tx_pin_out(tx_pin));

    sp0_remote_model u_model (
        .mclk_in(mclk_in), .uart_on_in(uart_on), .bit_len_in(bit_len),
        .tx_line_in(tx_pin), .data_line_in(pin_in), .line_out(model_line));

    always #5 mclk_in = ~mclk_in;

    always @(posedge mclk_in) begin
        tick_cnt <= tick_cnt + 8'h01;
        tx_tick  <= tick_cnt[1:0] == 2'h3;
        rx_tick  <= tick_cnt[0];
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ==========
    // Bus cycles and expectations
    task automatic bus(input logic [1:0] a, input logic [7:0] d, input logic w);
        bus_req.addr  <= a;
        bus_req.wdata <= d;
        bus_req.wr    <= w;
        bus_req.rd    <= !w;
        @(posedge mclk_in);
        bus_req.wr    <= 1'b0;
        bus_req.rd    <= 1'b0;
        @(posedge mclk_in);
    endtask : bus

    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        bus(a, 8'h00, 1'b0);
        v = rdata;
    endtask : rd

    task automatic wait_flag(input int b, output logic [7:0] v);
        for (int n = 0; n < 2000; n++) begin
            rd(CTRL_ADDR, v);
            if (v[b] === 1'b1) break;
        end
    endtask : wait_flag

    function automatic logic [10:0] exp_frame(input logic [1:0] m, input logic [7:0] d, input logic n9);
        return {1'b1, (m == MODE_UART8) ? 1'b1 : n9, d, 1'b0};
    endfunction : exp_frame

    task automatic wrap_up();
        $display("checks %0d, bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // ==========
    // Scenarios
    initial begin
        logic [7:0] d, v;
        logic       n9;
        int         stray;
        repeat (8) @(posedge mclk_in);
        reset_in <= 1'b0;
        @(posedge mclk_in);
        rd(CTRL_ADDR, v); `CHECK_EQ(v, CTRL_RESET)
        rd(CFG_ADDR, v); `CHECK_EQ(v, {5'h00, CFG_RESET})
        bus(2'h3, 8'hff, 1'b1);
        rd(2'h3, v); `CHECK_EQ(v, 8'h00)
        for (int r = 0; r < 2; r++) begin
            d = 8'($random(seed));
            bus(CFG_ADDR, 8'(r), 1'b1);
            bus(BUF_ADDR, d, 1'b1);
            wait_flag(CTRL_TI, v); `CHECK_EQ(v[CTRL_TI], 1'b1)
            repeat (4) @(posedge mclk_in);
            `CHECK_EQ(u_model.cap, d)
            bus(CTRL_ADDR, 8'h00, 1'b1);
        end
        d = 8'($random(seed));
        u_model.load_byte(d);
        bus(CFG_ADDR, 8'h00, 1'b1);
        bus(CTRL_ADDR, 8'h10, 1'b1);
        wait_flag(CTRL_RI, v);
        rd(BUF_ADDR, v); `CHECK_EQ(v, d)
        stray = 0;
        repeat (300) begin
            @(posedge mclk_in);
            stray += int'(tx_pin !== 1'b1);
        end
        `CHECK_EQ(stray, 0)
        bus(CTRL_ADDR, 8'h00, 1'b1);
        uart_on <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            d  = 8'($random(seed));
            n9 = 1'($random(seed));
            bit_len <= 8'(txlen[r]);
            bus(CFG_ADDR, cfgs[r], 1'b1);
            bus(CTRL_ADDR, {modes[r], 2'h0, n9, 3'h0}, 1'b1);
            bus(BUF_ADDR, d, 1'b1);
            wait_flag(CTRL_TI, v);
            repeat (3 * txlen[r]) @(posedge mclk_in);
            `CHECK_EQ(u_model.frame, exp_frame(modes[r], d, n9))
            bus(CTRL_ADDR, {modes[r], 6'h10}, 1'b1);
            u_model.send_frame(exp_frame(modes[r], d, n9), rxlen[r]);
            wait_flag(CTRL_RI, v); `CHECK_EQ(v[CTRL_RB8], (modes[r] == 2'h1) ? 1'b1 : n9)
            rd(BUF_ADDR, v); `CHECK_EQ(v, d)
        end
        // Flag still set: the next byte must be dropped
        u_model.send_frame(exp_frame(2'h3, ~d, 1'b0), 32);
        rd(BUF_ADDR, v); `CHECK_EQ(v, d)
        bus(CFG_ADDR, 8'h04, 1'b1);
        bus(CTRL_ADDR, 8'h50, 1'b1);
        u_model.send_frame({1'b0, 1'b1, d, 1'b0}, 32);
        wait_flag(CTRL_RI, v); `CHECK_EQ(v[CTRL_MODE_HI], 1'b1)
        bus(CTRL_ADDR, 8'h40, 1'b1);
        rd(CTRL_ADDR, v); `CHECK_EQ(v[CTRL_MODE_HI], 1'b0)
        wrap_up();
    end

endmodule : serial_port_zero_modes_bench

`default_nettype wire
